// File: pad_cfg_reg.sv
// One pad control register loaded with RESET_VALUE by hard or soft reset
`timescale 1ns/1ps
`include "padcfg_map.svh"
module pad_cfg_reg
	import padcfg_pkg::*;
#(
	parameter logic [15:0] RESET_VALUE = 16'h0000
) (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        soft_rst_i,
	input  wire logic        we_i,
	input  wire logic [15:0] wdata_i,
	output logic      [15:0] value_o,
	output pad_ctrl_t        ctrl_o
);
	logic [15:0] val_r;
	logic [15:0] val_nxt;

	always_comb begin
		val_nxt = val_r;
		if (soft_rst_i)
			val_nxt = RESET_VALUE;
		else if (we_i)
			val_nxt = wdata_i & `PAD_USED_MASK;
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			val_r <= RESET_VALUE;
		else
			val_r <= val_nxt;
	end

	assign value_o = val_r;
	assign ctrl_o  = '{pulldown_en: val_r[`PULL_BIT],
		slew_code: val_r[`SLEW_HI:`SLEW_LO],
		drive_code: val_r[`DRIVE_HI:`DRIVE_LO]};
endmodule : pad_cfg_reg

// File: padcfg_host_model.sv
// Host model issuing register cycles on the slave port
`timescale 1ns/1ps
module padcfg_host_model
	import padcfg_pkg::*;
(
	// Clock and read return
	input  wire logic        clk_i,
	input  wire logic [15:0] rdata_i,
	input  wire logic        rvalid_i,
	// Request to the bank
	output reg_req_t         req_o
);
	initial req_o = '0;
	// Released bus shows inverted values, never a stale copy
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge clk_i);
		req_o <= '{1'b1, 1'b0, a, d};
		@(posedge clk_i);
		req_o <= '{1'b0, 1'b0, ~a, ~d};
	endtask : wr
	task automatic rd(input logic [15:0] a, output logic [15:0] d,
		output logic v);
		@(posedge clk_i);
		req_o <= '{1'b0, 1'b1, a, 16'h0000};
		@(posedge clk_i);
		req_o <= '{1'b0, 1'b0, ~a, 16'hFFFF};
		@(posedge clk_i);
		d = rdata_i;
		v = rvalid_i;
	endtask : rd
endmodule : padcfg_host_model

// File: padcfg_map.svh
// Register offsets, field positions and reset values for the pad bank
`ifndef PADCFG_MAP_SVH
`define PADCFG_MAP_SVH
`define PIN_A_PAD_OFS      16'hF7A1
`define PIN_B_PAD_OFS      16'hF7A2
`define CLK_PAD_OFS        16'hF7A3
`define SOFT_RESET_OFS     16'hF890
`define PLL_FIRST_OFS      16'hF000
`define PLL_LAST_OFS       16'hF006
`define PIN_A_PAD_RST      16'h0018
`define PIN_B_PAD_RST      16'h0018
`define CLK_PAD_RST        16'h0008
`define SOFT_RESET_RST     16'h0001
`define PLL_WORD_RST       16'h0000
`define PULL_BIT           4
`define SLEW_HI            3
`define SLEW_LO            2
`define DRIVE_HI           1
`define DRIVE_LO           0
`define PAD_USED_MASK      16'h001F
`define SOFT_RESET_BIT     0
`endif

// File: padcfg_pkg.sv
// Types shared by the pad configuration and soft reset bank
package padcfg_pkg;
	typedef struct packed {
		logic       pulldown_en;
		logic [1:0] slew_code;
		logic [1:0] drive_code;
	} pad_ctrl_t;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [15:0] wdata;
	} reg_req_t;

	typedef enum logic [1:0] {
		PORT_I2C = 2'b01,
		PORT_SPI = 2'b10
	} port_mode_t;
endpackage : padcfg_pkg

// File: padcfg_soft_reset_properties.sv
// Port assertions for the pad and soft reset bank
`timescale 1ns/1ps
module padcfg_checker (
	// Clock, reset and register bus
	input wire logic        CLOCK_I,
	input wire logic        RSTN_I,
	input wire logic        REG_WR_I,
	input wire logic        REG_RD_I,
	input wire logic [15:0] REG_ADDR_I,
	input wire logic [15:0] REG_WDATA_I,
	input wire logic [15:0] REG_RDATA_O,
	input wire logic        REG_RVALID_O,
	// Mode, soft reset and pin A
	input wire logic        SPI_SELECT_I,
	input wire logic        SPI_MODE_O,
	input wire logic        SOFT_RESET_ACTIVE_O,
	input wire logic        PIN_A_PULLDOWN_EN_O,
	input wire logic [1:0]  PIN_A_SLEW_CODE_O,
	input wire logic [1:0]  PIN_A_DRIVE_CODE_O
);
	wire [4:0] pad_a = {PIN_A_PULLDOWN_EN_O, PIN_A_SLEW_CODE_O,
		PIN_A_DRIVE_CODE_O};
	wire soft_wr = REG_WR_I && REG_ADDR_I == 16'hF890;
	default clocking cb @(posedge CLOCK_I); endclocking
	default disable iff (!RSTN_I);
	property p_rvalid; REG_RD_I |=> REG_RVALID_O; endproperty
	property p_spi_set; SPI_SELECT_I |=> SPI_MODE_O; endproperty
	property p_spi_keep; SPI_MODE_O |=> SPI_MODE_O; endproperty
	property p_soft_on;
		soft_wr && !REG_WDATA_I[0] |=> SOFT_RESET_ACTIVE_O;
	endproperty
	property p_soft_off;
		soft_wr && REG_WDATA_I[0] |=> !SOFT_RESET_ACTIVE_O;
	endproperty
	property p_pad_dflt; SOFT_RESET_ACTIVE_O |=> pad_a == 5'h18; endproperty
	property p_pad_wr;
		REG_WR_I && REG_ADDR_I == 16'hF7A1 && !SOFT_RESET_ACTIVE_O
		|=> {11'h000, pad_a} == ($past(REG_WDATA_I) & 16'h001F);
	endproperty
	property p_clk_rsvd;
		REG_RD_I && REG_ADDR_I == 16'hF7A3 |=> REG_RDATA_O[15:5] == 11'h000;
	endproperty
	a_rvalid: assert property (p_rvalid) else $error("rvalid");
	a_spi_set: assert property (p_spi_set) else $error("spi");
	a_spi_keep: assert property (p_spi_keep) else $error("spi");
	a_soft_on: assert property (p_soft_on) else $error("soft");
	a_soft_off: assert property (p_soft_off) else $error("soft");
	a_pad_dflt: assert property (p_pad_dflt) else $error("pad");
	a_pad_wr: assert property (p_pad_wr) else $error("pad");
	a_clk_rsvd: assert property (p_clk_rsvd) else $error("rsvd");
	c_soft_rd: cover property (SOFT_RESET_ACTIVE_O && REG_RVALID_O);
	c_spi: cover property (SPI_SELECT_I && !SPI_MODE_O);
	c_soft_wr: cover property (soft_wr && !REG_WDATA_I[0]);
endmodule : padcfg_checker
bind padcfg_soft_reset_top padcfg_checker chk_u (.CLOCK_I(CLOCK_I),
	.RSTN_I(RSTN_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
	.REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
	.REG_RDATA_O(REG_RDATA_O), .REG_RVALID_O(REG_RVALID_O),
	.SPI_SELECT_I(SPI_SELECT_I), .SPI_MODE_O(SPI_MODE_O),
	.SOFT_RESET_ACTIVE_O(SOFT_RESET_ACTIVE_O),
	.PIN_A_PULLDOWN_EN_O(PIN_A_PULLDOWN_EN_O),
	.PIN_A_SLEW_CODE_O(PIN_A_SLEW_CODE_O),
	.PIN_A_DRIVE_CODE_O(PIN_A_DRIVE_CODE_O));

// File: padcfg_soft_reset_top.sv
// Pad configuration and soft reset register bank
`timescale 1ns/1ps
`include "padcfg_map.svh"
module padcfg_soft_reset_top
	import padcfg_pkg::*;
#(
	parameter int PLL_WORDS = 7
) (
	// Clock and hardware reset
	input  wire logic        CLOCK_I,
	input  wire logic        RSTN_I,
	// Register access from the slave port decoder
	input  wire logic        REG_WR_I,
	input  wire logic        REG_RD_I,
	input  wire logic [15:0] REG_ADDR_I,
	input  wire logic [15:0] REG_WDATA_I,
	output logic      [15:0] REG_RDATA_O,
	output logic             REG_RVALID_O,
	// Port mode select from the slave port
	input  wire logic        SPI_SELECT_I,
	output logic             SPI_MODE_O,
	// Soft reset state
	output logic             SOFT_RESET_ACTIVE_O,
	// Pad controls
	output logic             PIN_A_PULLDOWN_EN_O,
	output logic      [1:0]  PIN_A_SLEW_CODE_O,
	output logic      [1:0]  PIN_A_DRIVE_CODE_O,
	output logic             PIN_B_PULLDOWN_EN_O,
	output logic      [1:0]  PIN_B_SLEW_CODE_O,
	output logic      [1:0]  PIN_B_DRIVE_CODE_O,
	output logic             CLOCK_PIN_PULLDOWN_EN_O,
	output logic      [1:0]  CLOCK_PIN_SLEW_CODE_O,
	output logic      [1:0]  CLOCK_PIN_DRIVE_CODE_O
);
	reg_req_t    req;
	logic        soft_r;
	logic        soft_nxt;
	port_mode_t  mode_r;
	port_mode_t  mode_nxt;
	logic [15:0] rdata_r;
	logic [15:0] rdata_nxt;
	logic        rvalid_r;
	logic        rvalid_nxt;
	logic        in_soft;
	logic [15:0] a_val;
	logic [15:0] b_val;
	logic [15:0] c_val;
	pad_ctrl_t   a_ctrl;
	pad_ctrl_t   b_ctrl;
	pad_ctrl_t   c_ctrl;
	logic        pll_hit;
	logic [15:0] pll_rdata;

	initial begin
		if (PLL_WORDS != 7)
			$error("padcfg_soft_reset_top: PLL window is seven words");
	end

	assign req = '{wr: REG_WR_I, rd: REG_RD_I,
		addr: REG_ADDR_I, wdata: REG_WDATA_I};
	assign in_soft = !soft_r;

	// Soft reset bit, itself held out of the soft reset so it can be released
	always_comb begin
		soft_nxt = soft_r;
		if (req.wr && req.addr == `SOFT_RESET_OFS)
			soft_nxt = req.wdata[`SOFT_RESET_BIT];
	end

	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I)
			soft_r <= 1'(`SOFT_RESET_RST);
		else
			soft_r <= soft_nxt;
	end

	// Port mode: only the hardware reset pin returns it to I2C
	always_comb begin
		mode_nxt = mode_r;
		if (SPI_SELECT_I)
			mode_nxt = PORT_SPI;
	end

	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I)
			mode_r <= PORT_I2C;
		else
			mode_r <= mode_nxt;
	end

	pad_cfg_reg #(
		.RESET_VALUE (`PIN_A_PAD_RST)
	) u_pin_a (
		.clk_i      (CLOCK_I),
		.rst_n_i    (RSTN_I),
		.soft_rst_i (in_soft),
		.we_i       (req.wr && req.addr == `PIN_A_PAD_OFS),
		.wdata_i    (req.wdata),
		.value_o    (a_val),
		.ctrl_o     (a_ctrl)
	);

	pad_cfg_reg #(
		.RESET_VALUE (`PIN_B_PAD_RST)
	) u_pin_b (
		.clk_i      (CLOCK_I),
		.rst_n_i    (RSTN_I),
		.soft_rst_i (in_soft),
		.we_i       (req.wr && req.addr == `PIN_B_PAD_OFS),
		.wdata_i    (req.wdata),
		.value_o    (b_val),
		.ctrl_o     (b_ctrl)
	);

	pad_cfg_reg #(
		.RESET_VALUE (`CLK_PAD_RST)
	) u_clk_pin (
		.clk_i      (CLOCK_I),
		.rst_n_i    (RSTN_I),
		.soft_rst_i (in_soft),
		.we_i       (req.wr && req.addr == `CLK_PAD_OFS),
		.wdata_i    (req.wdata),
		.value_o    (c_val),
		.ctrl_o     (c_ctrl)
	);

	pll_word_bank #(
		.WORDS (PLL_WORDS)
	) u_pll (
		.clk_i   (CLOCK_I),
		.rst_n_i (RSTN_I),
		.we_i    (req.wr),
		.addr_i  (req.addr),
		.wdata_i (req.wdata),
		.hit_o   (pll_hit),
		.rdata_o (pll_rdata)
	);

	// Reads are never gated by soft reset, so the host keeps access
	always_comb begin
		rvalid_nxt = req.rd;
		rdata_nxt  = rdata_r;
		if (req.rd) begin
			unique case (req.addr)
				`PIN_A_PAD_OFS:  rdata_nxt = a_val;
				`PIN_B_PAD_OFS:  rdata_nxt = b_val;
				`CLK_PAD_OFS:    rdata_nxt = c_val;
				`SOFT_RESET_OFS: rdata_nxt = {15'h0000, soft_r};
				default:         rdata_nxt = pll_hit ? pll_rdata : 16'h0000;
			endcase
		end
	end

	always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
		if (!RSTN_I) begin
			rdata_r  <= 16'h0000;
			rvalid_r <= 1'b0;
		end else begin
			rdata_r  <= rdata_nxt;
			rvalid_r <= rvalid_nxt;
		end
	end

	// Outputs decoded only from flip-flops, SOFT_RESET_ACTIVE_O is inverted soft_r; pad fields pass through untouched
	assign REG_RDATA_O             = rdata_r;
	assign REG_RVALID_O            = rvalid_r;
	assign SPI_MODE_O              = (mode_r == PORT_SPI);
	assign SOFT_RESET_ACTIVE_O     = in_soft;
	assign PIN_A_PULLDOWN_EN_O     = a_ctrl.pulldown_en;
	assign PIN_A_SLEW_CODE_O       = a_ctrl.slew_code;
	assign PIN_A_DRIVE_CODE_O      = a_ctrl.drive_code;
	assign PIN_B_PULLDOWN_EN_O     = b_ctrl.pulldown_en;
	assign PIN_B_SLEW_CODE_O       = b_ctrl.slew_code;
	assign PIN_B_DRIVE_CODE_O      = b_ctrl.drive_code;
	assign CLOCK_PIN_PULLDOWN_EN_O = c_ctrl.pulldown_en;
	assign CLOCK_PIN_SLEW_CODE_O   = c_ctrl.slew_code;
	assign CLOCK_PIN_DRIVE_CODE_O  = c_ctrl.drive_code;
endmodule : padcfg_soft_reset_top

// File: pll_word_bank.sv
// PLL words kept across soft reset, cleared only by hard reset
`timescale 1ns/1ps
`include "padcfg_map.svh"
module pll_word_bank #(
	parameter int WORDS = 7
) (
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        we_i,
	input  wire logic [15:0] addr_i,
	input  wire logic [15:0] wdata_i,
	output logic             hit_o,
	output logic      [15:0] rdata_o
);
	logic [15:0] mem_r   [WORDS];
	logic [15:0] mem_nxt [WORDS];
	logic [15:0] idx;

	initial begin
		if (WORDS < 1 || WORDS > 256)
			$error("pll_word_bank: WORDS out of range");
	end

	assign idx   = addr_i - `PLL_FIRST_OFS;
	assign hit_o = (addr_i >= `PLL_FIRST_OFS) && (idx < 16'(WORDS));

	always_comb begin
		rdata_o = 16'h0000;
		for (int i = 0; i < WORDS; i++) begin
			mem_nxt[i] = mem_r[i];
			if (we_i && hit_o && idx == 16'(i))
				mem_nxt[i] = wdata_i;
			if (hit_o && idx == 16'(i))
				rdata_o = mem_r[i];
		end
	end

	// No soft reset input: contents survive it by construction
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < WORDS; i++)
				mem_r[i] <= `PLL_WORD_RST;
		end else begin
			mem_r <= mem_nxt;
		end
	end
endmodule : pll_word_bank

// File: tb_top.sv
// Self-checking bench for the pad and soft reset bank
`timescale 1ns/1ps
module tb_top
	import padcfg_pkg::*;
;
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        spi_sel = 1'b0;
	reg_req_t    req;
	wire  [15:0] rdata;
	wire         rvalid, spi_mode, soft_act;
	wire  [4:0]  pa, pb, pc;
	logic [15:0] d, exp_v [3];
	logic [31:0] seed = 32'h0000_ED6D;
	logic        v;
	int          fail_count = 0, check_count = 0, cyc = 0, k;
	always #5 clk = ~clk;
	padcfg_host_model hst (.clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid),
		.req_o(req));
	padcfg_soft_reset_top #(.PLL_WORDS(7)) dut_u (.CLOCK_I(clk),
		.RSTN_I(rst_n), .REG_WR_I(req.wr), .REG_RD_I(req.rd),
		.REG_ADDR_I(req.addr), .REG_WDATA_I(req.wdata), .REG_RDATA_O(rdata),
		.REG_RVALID_O(rvalid), .SPI_SELECT_I(spi_sel), .SPI_MODE_O(spi_mode),
		.SOFT_RESET_ACTIVE_O(soft_act), .PIN_A_PULLDOWN_EN_O(pa[4]),
		.PIN_A_SLEW_CODE_O(pa[3:2]), .PIN_A_DRIVE_CODE_O(pa[1:0]),
		.PIN_B_PULLDOWN_EN_O(pb[4]), .PIN_B_SLEW_CODE_O(pb[3:2]),
		.PIN_B_DRIVE_CODE_O(pb[1:0]), .CLOCK_PIN_PULLDOWN_EN_O(pc[4]),
		.CLOCK_PIN_SLEW_CODE_O(pc[3:2]), .CLOCK_PIN_DRIVE_CODE_O(pc[1:0]));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	function automatic logic [15:0] dflt(input int i);
		return (i == 2) ? 16'h0008 : 16'h0018;
	endfunction : dflt
	function automatic logic [15:0] pad(input int i);
		return {11'h000, (i == 0) ? pa : (i == 1) ? pb : pc};
	endfunction : pad
	task automatic chk(input string n, input logic [15:0] s, e);
		check_count++;
		if (s !== e) begin
			fail_count++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic rc(input logic [15:0] a, input logic [15:0] e);
		hst.rd(a, d, v);
		chk("rvalid", {15'h0, v}, 16'h0001);
		chk("rdata", d, e);
	endtask : rc
	task automatic give_verdict();
		$display("checks %0d errors %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict
	// Whole run needs about 120 cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			fail_count++;
			give_verdict();
		end
	end
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 3; i++) begin
			exp_v[i] = dflt(i);
			rc(16'hF7A1 + 16'(i), exp_v[i]);
			chk("pad", pad(i), exp_v[i]);
		end
		rc(16'hF890, 16'h0001);
		rc(16'h1234, 16'h0000);
		for (int i = 0; i < 12; i++) begin
			seed = lfsr(seed);
			k = int'(seed[7:0]) % 3;
			hst.wr(16'hF7A1 + 16'(k), seed[31:16]);
			exp_v[k] = seed[31:16] & 16'h001F;
			rc(16'hF7A1 + 16'(k), exp_v[k]);
			chk("pad", pad(k), exp_v[k]);
		end
		hst.wr(16'hF003, 16'hA5C3);
		@(posedge clk) spi_sel <= 1'b1;
		@(posedge clk) spi_sel <= 1'b0;
		hst.wr(16'hF890, 16'h0000);
		rc(16'hF890, 16'h0000);
		chk("soft", {15'h0, soft_act}, 16'h0001);
		hst.wr(16'hF7A1, 16'h0003);
		hst.wr(16'hF000, 16'h1357);
		for (int i = 0; i < 3; i++)
			rc(16'hF7A1 + 16'(i), dflt(i));
		hst.wr(16'hF890, 16'h0001);
		rc(16'hF000, 16'h1357);
		rc(16'hF003, 16'hA5C3);
		chk("soft", {15'h0, soft_act}, 16'h0000);
		chk("spi", {15'h0, spi_mode}, 16'h0001);
		@(posedge clk) rst_n <= 1'b0;
		@(posedge clk) rst_n <= 1'b1;
		rc(16'hF000, 16'h0000);
		chk("spi", {15'h0, spi_mode}, 16'h0000);
		give_verdict();
	end
endmodule : tb_top
